// file: common/period_timer_pkg.sv
/*
 * Package for the 8-bit period match timer: register map, field layout,
 * reset values and bus record types.
 * Assumes an Avalon-MM slave with 32-bit data; each register sits in the
 * low byte of one aligned word.
 */
// Functional notes
// - count clock is instruction clock, oscillator/4
// - count and period registers are 8-bit read/write
// - count increments by one per prescaled tick
// - prescale select gives 1, 4, 16, 64
// - compare count with period every cycle
// - match restarts count and advances postscaler
// - reset clears count, sets period FFh
// - count/control writes and reset clear scalers
// - control write keeps the count value
// - postscaler reaching selection sets match flag
// - interrupt forwarded only when enable set
// - postscale ratio is select value plus one
// - unscaled match goes to PWM unit
// - match offered as serial shift clock
// - no counting in sleep, registers kept
// - control bits: postscale, run, prescale
// - control bit 7 reads zero
package period_timer_pkg;

  localparam logic [3:0] addr_count = 4'h0;
  localparam logic [3:0] addr_period = 4'h4;
  localparam logic [3:0] addr_control = 4'h8;
  localparam logic [3:0] addr_flag = 4'hC;
  localparam int addr_bits = 4;

  localparam logic [7:0] count_reset = 8'h00;
  localparam logic [7:0] period_reset = 8'hFF;
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] control_mask = 8'h7F;

  localparam int post_lsb = 3;
  localparam int run_bit = 2;
  localparam int pre_lsb = 0;
  localparam int flag_bit = 0;
  localparam int enable_bit = 1;

  localparam logic [1:0] inst_div = 2'h3;
  localparam logic [1:0] pre_div1 = 2'h0;
  localparam logic [1:0] pre_div4 = 2'h1;
  localparam logic [1:0] pre_div16 = 2'h2;

  typedef struct packed {
    logic [addr_bits-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bus_req_s;

  typedef struct packed {
    logic [3:0] postscale_select;
    logic timer_run;
    logic [1:0] prescale_select;
  } control_s;

endpackage

// file: rtl/period_match_timer_8bit.sv
/*
 * 8-bit period match timer with prescaler, period compare and postscaler,
 * reached as an Avalon-MM slave.
 * Assumes ref_clk is the oscillator clock; sleep is a level from the
 * power controller, synchronous to ref_clk.
 */
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module period_match_timer_8bit (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sleep,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic match_pulse,
  output logic shift_clock
);

  period_timer_pkg::bus_req_s req;
  period_timer_pkg::control_s ctl;

  logic [7:0] count_reg, count_next;
  logic [7:0] period_reg;
  logic [6:0] control_reg;
  logic [5:0] prescale_reg, prescale_next;
  logic [3:0] postscale_reg, postscale_next;
  logic [1:0] inst_reg;
  logic match_flag_reg, match_irq_enable_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic match_pulse_reg, shift_clock_reg, irq_reg;

  assign req = '{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable};
  assign ctl = period_timer_pkg::control_s'(control_reg);

  // one access answered per two cycles: first cycle waits, second acks
  wire access = (req.read | req.write) & ~ack_reg;
  wire wr_en = req.write & ack_reg & req.byteenable[0];
  wire wr_count = wr_en & (req.address == period_timer_pkg::addr_count);
  wire wr_period = wr_en & (req.address == period_timer_pkg::addr_period);
  wire wr_control = wr_en & (req.address == period_timer_pkg::addr_control);
  wire wr_flag = wr_en & (req.address == period_timer_pkg::addr_flag);
  wire [7:0] wbyte = req.writedata[7:0];

  // instruction clock tick: one per four oscillator cycles
  wire inst_tick = (inst_reg == period_timer_pkg::inst_div);
  wire running = ctl.timer_run & ~sleep;

  function automatic logic pre_done(input logic [1:0] sel, input logic [5:0] cnt);
    case (sel)
      period_timer_pkg::pre_div1: pre_done = 1'b1;
      period_timer_pkg::pre_div4: pre_done = (cnt[1:0] == 2'h3);
      period_timer_pkg::pre_div16: pre_done = (cnt[3:0] == 4'hF);
      default: pre_done = (cnt == 6'h3F);
    endcase
  endfunction

  wire cnt_tick = running & inst_tick & pre_done(ctl.prescale_select, prescale_reg);
  // compare every cycle; only a count tick on equality makes one match event,
  // so a slow prescaler cannot repeat the match while the count dwells
  wire match = cnt_tick & (count_reg == period_reg);
  wire post_hit = match & (postscale_reg == ctl.postscale_select);
  wire clr_scalers = wr_count | wr_control;

  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = wbyte;
    end else if (cnt_tick) begin
      // match restarts from zero instead of incrementing
      count_next = (count_reg == period_reg) ? 8'h00 : count_reg + 8'h01;
    end
    prescale_next = prescale_reg;
    if (clr_scalers) begin
      prescale_next = 6'h00;
    end else if (running & inst_tick) begin
      prescale_next = cnt_tick ? 6'h00 : prescale_reg + 6'h01;
    end
    postscale_next = postscale_reg;
    if (clr_scalers) begin
      postscale_next = 4'h0;
    end else if (cnt_tick & (count_reg == period_reg)) begin
      postscale_next = post_hit ? 4'h0 : postscale_reg + 4'h1;
    end
  end

  // flag set wins over a one-to-clear in the same cycle
  wire flag_next = post_hit | (match_flag_reg & ~(wr_flag & wbyte[period_timer_pkg::flag_bit]));

  wire [7:0] rd_byte =
    (req.address == period_timer_pkg::addr_count) ? count_reg :
    (req.address == period_timer_pkg::addr_period) ? period_reg :
    (req.address == period_timer_pkg::addr_control) ? {1'b0, control_reg} :
    (req.address == period_timer_pkg::addr_flag) ? {6'h00, match_irq_enable_reg, match_flag_reg} :
    8'h00;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count_reg <= period_timer_pkg::count_reset;
      period_reg <= period_timer_pkg::period_reset;
      control_reg <= period_timer_pkg::control_reset[6:0];
      prescale_reg <= 6'h00;
      postscale_reg <= 4'h0;
      inst_reg <= 2'h0;
      match_flag_reg <= 1'b0;
      match_irq_enable_reg <= 1'b0;
    end else begin
      // sleep stops the instruction clock too
      inst_reg <= sleep ? inst_reg : inst_reg + 2'h1;
      count_reg <= count_next;
      prescale_reg <= prescale_next;
      postscale_reg <= postscale_next;
      match_flag_reg <= flag_next;
      if (wr_period) begin
        period_reg <= wbyte;
      end
      if (wr_control) begin
        control_reg <= wbyte[6:0]; // count untouched
      end
      if (wr_flag) begin
        match_irq_enable_reg <= wbyte[period_timer_pkg::enable_bit];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
      match_pulse_reg <= 1'b0;
      shift_clock_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ack_reg <= access;
      readdata_reg <= access ? {24'h000000, rd_byte} : readdata_reg;
      match_pulse_reg <= match;
      // match toggles a square shift clock
      shift_clock_reg <= shift_clock_reg ^ match;
      irq_reg <= flag_next & match_irq_enable_reg;
    end
  end

  assign avs_waitrequest = ~ack_reg;
  assign avs_readdata = readdata_reg;
  assign match_pulse = match_pulse_reg;
  assign shift_clock = shift_clock_reg;
  assign irq = irq_reg;

endmodule

// file: verif/period_timer_props.sv
/* assertions on the ports of period_match_timer_8bit
   assumes one clock, ref_clk, with reset_n synchronous active low */
`timescale 1ns/1ps
module period_timer_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sleep,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic match_pulse,
  input wire logic shift_clock
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire rq = avs_read | avs_write;
  wire rd_ok = avs_read & !avs_waitrequest;
  a_wait_one: assert property (rq && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  a_wait_idle: assert property (!rq |=> avs_waitrequest) else $error("answer without request");
  a_upper_zero: assert property (avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  a_ctrl_bit7: assert property (rd_ok && avs_address == period_timer_pkg::addr_control |-> !avs_readdata[7])
    else $error("control bit 7 set");
  a_flag_spare: assert property (rd_ok && avs_address == period_timer_pkg::addr_flag |-> avs_readdata[7:2] == 6'h0)
    else $error("flag spare bits set");
  a_pulse_gap: assert property (match_pulse |=> !match_pulse [*3]) else $error("matches too close");
  a_sleep_hold: assert property (sleep && $past(sleep) |-> !match_pulse && $stable(shift_clock))
    else $error("activity in sleep");
  a_shift_follow: assert property ($changed(shift_clock) |-> (match_pulse || $past(match_pulse)) or (##1 match_pulse))
    else $error("shift clock without match");
endmodule
bind period_match_timer_8bit period_timer_props i_props (.*);

// file: verif/period_match_timer_8bit_tb.sv
/* self-checking bench for period_match_timer_8bit
   assumes the port checker is bound from its own file */
`timescale 1ns/1ps
module period_match_timer_8bit_tb;
  logic ref_clk = 0, reset_n = 0, sleep = 0, avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'h0A45AD3D;
  logic avs_waitrequest, irq, match_pulse, shift_clock;
  logic [7:0] q, c;
  int error_cnt = 0, checked = 0, n;
  period_match_timer_8bit i_dut (.*);
  always #12.5 ref_clk = !ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic int span(input int i, input int p);
    return 4 * (4 ** i) * (p + 1);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // counts cycles between two match pulses
  task automatic per(output int k);
    do @(negedge ref_clk); while (match_pulse !== 1'b1);
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (match_pulse !== 1'b1 && k < 9999);
  endtask
  initial begin
    #500000;
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    bus(4'h0, 0, 0); chk(q, 16'h00);
    bus(4'h4, 0, 0); chk(q, 16'hFF);
    bus(4'h8, 0, 0); chk(q, 16'h00);
    bus(4'h1, 0, 0); chk(q, 16'h00);
    avs_byteenable <= 4'h0;
    bus(4'h4, 1, 8'h11);
    avs_byteenable <= 4'hF;
    bus(4'h4, 0, 0); chk(q, 16'hFF);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      c = {6'h0, seed[1:0]} + 8'h1;
      bus(4'h4, 1, c); bus(4'h4, 0, 0); chk(q, c);
      bus(4'h8, 1, {1'b1, seed[7:4], 1'b1, 2'(i)}); bus(4'h8, 0, 0); chk(q, {1'b0, seed[7:4], 1'b1, 2'(i)});
      // restart below the period so the first match comes without a wrap
      bus(4'h0, 1, 8'h00);
      per(n); chk(n[15:0], 16'(span(i, c)));
    end
    bus(4'h4, 1, 0);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      c = (i == 0) ? 8'h0 : (i == 1) ? 8'hF : {4'h0, seed[3:0]};
      bus(4'h8, 1, {1'b0, c[3:0], 3'b000});
      bus(4'hC, 1, 8'h03);
      bus(4'h8, 1, {1'b0, c[3:0], 3'b100});
      n = 0;
      do begin
        @(negedge ref_clk);
        n += match_pulse;
      end while (irq !== 1'b1 && n < 99);
      chk(n[15:0], 16'(c + 1));
    end
    bus(4'hC, 1, 8'h01);
    repeat (200) @(negedge ref_clk);
    chk(irq, 0);
    bus(4'hC, 0, 0); chk(q[0], 1);
    bus(4'h8, 1, 8'h00); bus(4'h0, 1, 8'h5A);
    repeat (40) @(negedge ref_clk);
    bus(4'h0, 0, 0); chk(q, 16'h5A);
    bus(4'h8, 1, 8'h7B); bus(4'h0, 0, 0); chk(q, 16'h5A);
    bus(4'h4, 1, 8'hFF); bus(4'h8, 1, 8'h04);
    sleep <= 1'b1;
    bus(4'h0, 0, 0);
    c = q;
    repeat (100) @(negedge ref_clk);
    bus(4'h0, 0, 0); chk(q, c);
    sleep <= 1'b0;
    repeat (100) @(negedge ref_clk);
    bus(4'h0, 0, 0); chk(q == c, 0);
    final_report;
  end
endmodule
